// ==== src/acsf_cfg.svh ====
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 4-bit register address, 8-bit register data
// Notes: included by the top module only
`ifndef ACSF_CFG_SVH
`define ACSF_CFG_SVH

// register offsets
`define ACSF_OFS_CHAN     4'h0
`define ACSF_OFS_PRE      4'h1
`define ACSF_OFS_ACQ      4'h2
`define ACSF_OFS_CAP      4'h3
`define ACSF_OFS_RPT      4'h4
`define ACSF_OFS_CNT      4'h5
`define ACSF_OFS_FLT_H    4'h6
`define ACSF_OFS_FLT_L    4'h7
`define ACSF_OFS_CTRL     4'h8
`define ACSF_OFS_DIV      4'h9
`define ACSF_OFS_COMP     4'ha
`define ACSF_OFS_STAT     4'hb

// control register fields
`define ACSF_CTRL_GO      0
`define ACSF_CTRL_RCSRC   1
// computation register fields
`define ACSF_COMP_MD_LSB  0
`define ACSF_COMP_CLR     3
`define ACSF_COMP_SH_LSB  4
// status register fields
`define ACSF_STAT_OVF     7
`define ACSF_STAT_THR     6

// channel codes
`define ACSF_CH_VREF      6'h3f
`define ACSF_CH_DAC       6'h3e
`define ACSF_CH_TEMP      6'h3d
`define ACSF_CH_GND       6'h3c
`define ACSF_CH_PORTC_HI  3'h2

// reset value, counter saturation value and largest legal shift code
`define ACSF_RST_BYTE     8'h00
`define ACSF_CNT_SAT      8'hff
`define ACSF_SHIFT_MAX    3'h5

// long acquisition when the acquisition field is zero behind a precharge
`define ACSF_ACQ_LONG     9'h100

`endif

// ==== src/acsf_pkg.sv ====
// Purpose: shared types of the converter sequence and filter block
// Assumes: nothing beyond SystemVerilog
// Notes: numbers live in acsf_cfg.svh
package acsf_pkg;

  // computation modes; 101 and above are reserved
  typedef enum logic [2:0] {
    ACSF_MD_BASIC = 3'b000,
    ACSF_MD_ACCUM = 3'b001,
    ACSF_MD_AVG   = 3'b010,
    ACSF_MD_BURST = 3'b011,
    ACSF_MD_LPF   = 3'b100
  } acsf_mode_t;

  // conversion cycle phases
  typedef enum logic [1:0] {
    ACSF_ST_IDLE = 2'b00,
    ACSF_ST_PRE  = 2'b01,
    ACSF_ST_ACQ  = 2'b10,
    ACSF_ST_CONV = 2'b11
  } acsf_state_t;

endpackage

// ==== src/acsf_top.sv ====
// Purpose: channel, timing, capacitor, repeat and filter registers of a converter
// Assumes: core_clk 40 MHz, srst synchronous active high, core on core_clk
// Notes: rc_tick is an asynchronous pin, synchronised before use
`timescale 1ns/100ps
`default_nettype none
`include "acsf_cfg.svh"

module acsf_top #(
  parameter int RESULT_W = 10,
  parameter int ACC_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // dedicated rc oscillator pin
  input wire logic rc_tick,
  // converter core
  input wire logic conv_done,
  input wire logic [RESULT_W-1:0] conv_result,
  output logic conv_start,
  output logic conv_clk_en,
  output logic precharge_on,
  output logic acquire_on,
  // analog input multiplexer
  output logic sel_vref,
  output logic sel_dac,
  output logic sel_temp,
  output logic sel_gnd,
  output logic sel_none,
  output logic [2:0] sel_port,
  output logic [2:0] pin_index,
  // sample capacitor
  output logic [4:0] cap_pf,
  // threshold check pulse
  output logic thresh_check
);

  // elaboration check: the result must fit the accumulator with a sign bit
  if (RESULT_W < 1 || RESULT_W >= ACC_W || ACC_W != 16) begin : g_bad_width
    $error("acsf_top: RESULT_W must be below ACC_W, and ACC_W must be 16");
  end

  // software registers and internal state
  logic [5:0] chan_reg;
  logic [7:0] pre_reg;
  logic [7:0] acq_reg;
  logic [4:0] cap_reg;
  logic [7:0] rpt_reg;
  logic [7:0] cnt_reg;
  logic go_reg;
  logic rcsrc_reg;
  logic [5:0] div_reg;
  logic [2:0] mode_reg;
  logic clr_reg;
  logic [2:0] shift_reg;
  logic ovf_reg;
  logic thr_reg;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [ACC_W-1:0] flt_reg;
  acsf_pkg::acsf_state_t state_reg;
  acsf_pkg::acsf_state_t state_next;
  logic [8:0] timer_reg;
  logic [8:0] timer_next;
  logic [6:0] divcnt_reg;
  logic rc_s1_reg;
  logic rc_s2_reg;
  logic rc_s3_reg;

  // register port decode
  wire wr_chan = reg_wr && (reg_addr == `ACSF_OFS_CHAN);
  wire wr_pre = reg_wr && (reg_addr == `ACSF_OFS_PRE);
  wire wr_acq = reg_wr && (reg_addr == `ACSF_OFS_ACQ);
  wire wr_cap = reg_wr && (reg_addr == `ACSF_OFS_CAP);
  wire wr_rpt = reg_wr && (reg_addr == `ACSF_OFS_RPT);
  wire wr_cnt = reg_wr && (reg_addr == `ACSF_OFS_CNT);
  wire wr_ctrl = reg_wr && (reg_addr == `ACSF_OFS_CTRL);
  wire wr_div = reg_wr && (reg_addr == `ACSF_OFS_DIV);
  wire wr_comp = reg_wr && (reg_addr == `ACSF_OFS_COMP);

  // mode decode; reserved codes behave as basic
  wire [2:0] md = mode_reg;
  wire md_acc_family = (md == acsf_pkg::ACSF_MD_ACCUM) || (md == acsf_pkg::ACSF_MD_AVG) ||
                       (md == acsf_pkg::ACSF_MD_BURST);
  wire md_lpf = (md == acsf_pkg::ACSF_MD_LPF);
  wire md_checked = (md == acsf_pkg::ACSF_MD_AVG) || (md == acsf_pkg::ACSF_MD_BURST) || md_lpf;
  // reserved shift codes clamp to the largest legal one
  wire [2:0] sh = (shift_reg > `ACSF_SHIFT_MAX) ? `ACSF_SHIFT_MAX : shift_reg;

  // rc pin synchroniser and edge detect; stage one feeds stage two only
  always_ff @(posedge core_clk) begin
    rc_s1_reg <= rc_tick;
    rc_s2_reg <= rc_s1_reg;
    rc_s3_reg <= rc_s2_reg;
  end
  wire rc_en = rc_s2_reg && !rc_s3_reg;

  // system clock divider: one pulse every 2*(div+1) core clocks
  wire [6:0] div_last = {div_reg, 1'b1};
  wire div_en = (divcnt_reg == div_last);
  always_ff @(posedge core_clk) begin
    if (srst || div_en) begin
      divcnt_reg <= 7'h00;
    end else begin
      divcnt_reg <= divcnt_reg + 7'h01;
    end
  end

  // converter clock enable and phase tick
  wire conv_tick = rcsrc_reg ? rc_en : div_en;
  wire phase_tick = rcsrc_reg ? rc_en : 1'b1;

  // phase lengths, acquisition zero widened behind a precharge
  wire pre_used = (pre_reg != 8'h00);
  wire [8:0] acq_len = (acq_reg == 8'h00) ? (pre_used ? `ACSF_ACQ_LONG : 9'h000)
                                           : {1'b0, acq_reg};
  wire acq_used = (acq_len != 9'h000);
  wire start_cycle = go_reg && (state_reg == acsf_pkg::ACSF_ST_IDLE);
  wire timer_last = phase_tick && (timer_reg == 9'h001);

  // phase sequencer next state
  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    unique case (state_reg)
      acsf_pkg::ACSF_ST_IDLE: begin
        if (start_cycle) begin
          if (pre_used) begin
            state_next = acsf_pkg::ACSF_ST_PRE;
            timer_next = {1'b0, pre_reg};
          end else if (acq_used) begin
            state_next = acsf_pkg::ACSF_ST_ACQ;
            timer_next = acq_len;
          end else begin
            state_next = acsf_pkg::ACSF_ST_CONV;
          end
        end
      end
      acsf_pkg::ACSF_ST_PRE: begin
        if (timer_last) begin
          state_next = acsf_pkg::ACSF_ST_ACQ;
          timer_next = acq_len;
        end else if (phase_tick) begin
          timer_next = timer_reg - 9'h001;
        end
      end
      acsf_pkg::ACSF_ST_ACQ: begin
        if (timer_last) begin
          state_next = acsf_pkg::ACSF_ST_CONV;
        end else if (phase_tick) begin
          timer_next = timer_reg - 9'h001;
        end
      end
      acsf_pkg::ACSF_ST_CONV: begin
        if (conv_done) begin
          state_next = acsf_pkg::ACSF_ST_IDLE;
        end
      end
    endcase
  end

  // phase sequencer registers and phase outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= acsf_pkg::ACSF_ST_IDLE;
      timer_reg <= 9'h000;
      precharge_on <= 1'b0;
      acquire_on <= 1'b0;
      conv_start <= 1'b0;
      conv_clk_en <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      precharge_on <= (state_next == acsf_pkg::ACSF_ST_PRE);
      acquire_on <= (state_next == acsf_pkg::ACSF_ST_ACQ);
      conv_start <= (state_next == acsf_pkg::ACSF_ST_CONV) && (state_reg != acsf_pkg::ACSF_ST_CONV);
      conv_clk_en <= conv_tick && (state_reg == acsf_pkg::ACSF_ST_CONV);
    end
  end

  // sample arithmetic, zero-extended from the unsigned result
  wire signed [ACC_W:0] sample_x = {{(ACC_W+1-RESULT_W){1'b0}}, conv_result};
  wire signed [ACC_W:0] acc_sum = {acc_reg[ACC_W-1], acc_reg} + sample_x;
  wire acc_ovf = (acc_sum[ACC_W] != acc_sum[ACC_W-1]);
  // unity-gain low-pass: y += (x - y) / 2^shift, truncated
  wire signed [ACC_W:0] lpf_diff = sample_x - {acc_reg[ACC_W-1], acc_reg};
  wire signed [ACC_W:0] lpf_step = lpf_diff >>> sh;
  wire signed [ACC_W:0] lpf_sum = {acc_reg[ACC_W-1], acc_reg} + lpf_step;
  wire lpf_ovf = (lpf_sum[ACC_W] != lpf_sum[ACC_W-1]);
  wire signed [ACC_W-1:0] acc_new = md_lpf ? lpf_sum[ACC_W-1:0] : acc_sum[ACC_W-1:0];
  wire signed [ACC_W-1:0] shifted_new = acc_new >>> sh;
  wire sample_in = conv_done && (state_reg == acsf_pkg::ACSF_ST_CONV);
  wire check_due = md_checked && (cnt_reg >= rpt_reg);

  // overflow of the sample being taken; a set in the clear cycle survives
  wire acc_take = sample_in && (md_acc_family || md_lpf);
  wire ovf_set = acc_take && (md_lpf ? lpf_ovf : acc_ovf);

  // accumulator and overflow; clear beats a sample, an overflow beats clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      acc_reg <= '0;
      ovf_reg <= 1'b0;
    end else begin
      if (clr_reg) begin
        acc_reg <= '0;
      end else if (acc_take) begin
        acc_reg <= acc_new;
      end
      if (ovf_set) begin
        ovf_reg <= 1'b1;
      end else if (clr_reg) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // filter output follows each computed sample; basic mode leaves it alone
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flt_reg <= '0;
    end else if (sample_in && md_acc_family) begin
      flt_reg <= shifted_new;
    end else if (sample_in && md_lpf) begin
      flt_reg <= acc_new;
    end
  end

  // threshold check pulse and sticky status; a new check beats a clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      thresh_check <= 1'b0;
      thr_reg <= 1'b0;
    end else begin
      thresh_check <= sample_in && check_due;
      if (sample_in && check_due) begin
        thr_reg <= 1'b1;
      end else if (wr_comp) begin
        thr_reg <= 1'b0;
      end
    end
  end

  // conversion counter; trigger beats software write, clear beats both
  always_ff @(posedge core_clk) begin
    if (srst || clr_reg) begin
      cnt_reg <= `ACSF_RST_BYTE;
    end else if (start_cycle) begin
      if (cnt_reg != `ACSF_CNT_SAT) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end else if (wr_cnt) begin
      cnt_reg <= reg_wdata;
    end
  end

  // go bit: software sets it, end of conversion clears it, set wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      go_reg <= 1'b0;
    end else if (wr_ctrl && reg_wdata[`ACSF_CTRL_GO]) begin
      go_reg <= 1'b1;
    end else if (sample_in || (wr_ctrl && !reg_wdata[`ACSF_CTRL_GO])) begin
      go_reg <= 1'b0;
    end
  end

  // clear command self-clears on the same edge at which it acts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      clr_reg <= 1'b0;
    end else if (wr_comp && reg_wdata[`ACSF_COMP_CLR]) begin
      clr_reg <= 1'b1;
    end else begin
      clr_reg <= 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      chan_reg <= 6'h00;
      pre_reg <= `ACSF_RST_BYTE;
      acq_reg <= `ACSF_RST_BYTE;
      cap_reg <= 5'h00;
      rpt_reg <= `ACSF_RST_BYTE;
      rcsrc_reg <= 1'b0;
      div_reg <= 6'h00;
      mode_reg <= 3'h0;
      shift_reg <= 3'h0;
    end else begin
      if (wr_chan) chan_reg <= reg_wdata[5:0];
      if (wr_pre) pre_reg <= reg_wdata;
      if (wr_acq) acq_reg <= reg_wdata;
      if (wr_cap) cap_reg <= reg_wdata[4:0];
      if (wr_rpt) rpt_reg <= reg_wdata;
      if (wr_ctrl) rcsrc_reg <= reg_wdata[`ACSF_CTRL_RCSRC];
      if (wr_div) div_reg <= reg_wdata[5:0];
      if (wr_comp) mode_reg <= reg_wdata[`ACSF_COMP_MD_LSB +: 3];
      if (wr_comp) shift_reg <= reg_wdata[`ACSF_COMP_SH_LSB +: 3];
    end
  end

  // channel decode
  wire is_port_pin = (chan_reg[5:3] <= `ACSF_CH_PORTC_HI);
  wire is_named = (chan_reg == `ACSF_CH_VREF) || (chan_reg == `ACSF_CH_DAC) ||
                  (chan_reg == `ACSF_CH_TEMP) || (chan_reg == `ACSF_CH_GND);

  // multiplexer and capacitor outputs, registered
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sel_vref <= 1'b0;
      sel_dac <= 1'b0;
      sel_temp <= 1'b0;
      sel_gnd <= 1'b0;
      sel_none <= 1'b0;
      sel_port <= 3'h0;
      pin_index <= 3'h0;
      cap_pf <= 5'h00;
    end else begin
      sel_vref <= (chan_reg == `ACSF_CH_VREF);
      sel_dac <= (chan_reg == `ACSF_CH_DAC);
      sel_temp <= (chan_reg == `ACSF_CH_TEMP);
      sel_gnd <= (chan_reg == `ACSF_CH_GND);
      sel_none <= !is_port_pin && !is_named;
      sel_port <= is_port_pin ? (3'h1 << chan_reg[4:3]) : 3'h0;
      pin_index <= chan_reg[2:0];
      cap_pf <= cap_reg;
    end
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      `ACSF_OFS_CHAN: rd_mux = {2'b00, chan_reg};
      `ACSF_OFS_PRE: rd_mux = pre_reg;
      `ACSF_OFS_ACQ: rd_mux = acq_reg;
      `ACSF_OFS_CAP: rd_mux = {3'b000, cap_reg};
      `ACSF_OFS_RPT: rd_mux = rpt_reg;
      `ACSF_OFS_CNT: rd_mux = cnt_reg;
      `ACSF_OFS_FLT_H: rd_mux = flt_reg[15:8];
      `ACSF_OFS_FLT_L: rd_mux = flt_reg[7:0];
      `ACSF_OFS_CTRL: rd_mux = {6'h00, rcsrc_reg, go_reg};
      `ACSF_OFS_DIV: rd_mux = {2'b00, div_reg};
      `ACSF_OFS_COMP: rd_mux = {1'b0, shift_reg, clr_reg, mode_reg};
      `ACSF_OFS_STAT: rd_mux = {ovf_reg, thr_reg, 4'h0, state_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data stand one cycle after the strobe and only then
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ==== tb/acsf_core_model.sv ====
// Purpose: stand-in for the converter core behind the block
// Assumes: core_clk domain, answer delay and sample set by the bench
// Notes: result bus shows junk outside the done cycle
`timescale 1ns/100ps
`default_nettype none
module acsf_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // from the block and the bench
  input wire logic conv_start,
  input wire logic [7:0] delay,
  input wire logic [9:0] sample,
  // answer
  output logic conv_done,
  output logic [9:0] conv_result
);
  logic [7:0] cnt_reg;
  logic busy_reg;
  logic [9:0] last_reg;
  // slow or prompt answer; inverse of the last value so a stale read shows
  always_ff @(posedge core_clk) begin
    conv_done <= 1'b0;
    conv_result <= ~last_reg;
    if (srst) begin
      busy_reg <= 1'b0;
      last_reg <= 10'h000;
    end else if (conv_start) begin
      busy_reg <= 1'b1;
      cnt_reg <= delay;
    end else if (busy_reg && cnt_reg == 8'h00) begin
      busy_reg <= 1'b0;
      conv_done <= 1'b1;
      conv_result <= sample;
      last_reg <= sample;
    end else if (busy_reg) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== tb/acsf_top_assertions.sv ====
// Purpose: port-level checks of the sequence and filter block
// Assumes: one clock domain, srst synchronous
// Notes: attached by bind below
`timescale 1ns/100ps
`default_nettype none
module acsf_top_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port and sequencing
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_done,
  input wire logic conv_start,
  input wire logic conv_clk_en,
  input wire logic precharge_on,
  input wire logic acquire_on,
  input wire logic thresh_check,
  // multiplexer
  input wire logic sel_vref,
  input wire logic sel_dac,
  input wire logic sel_temp,
  input wire logic sel_gnd,
  input wire logic sel_none,
  input wire logic [2:0] sel_port
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // read data only in the answer cycle
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  // at most one source on the converter input
  chk_sel_single: assert property ($onehot0({sel_vref, sel_dac, sel_temp, sel_gnd, sel_none, |sel_port}))
    else $error("two inputs selected");
  chk_port_single: assert property ($onehot0(sel_port))
    else $error("two ports selected");
  // phase order
  chk_phase_excl: assert property (!(precharge_on && acquire_on))
    else $error("phases overlap");
  chk_pre_then_acq: assert property ($fell(precharge_on) |-> acquire_on)
    else $error("acquisition missing after precharge");
  chk_acq_then_conv: assert property ($fell(acquire_on) |-> conv_start)
    else $error("conversion missing after acquisition");
  chk_start_single: assert property (conv_start |=> !conv_start && !precharge_on && !acquire_on)
    else $error("start pulse too long");
  // converter clock pulses only inside the conversion phase
  chk_clk_en_conv: assert property (conv_clk_en |-> !precharge_on && !acquire_on && !conv_start)
    else $error("converter clock outside conversion");
  // threshold check only right after a result
  chk_thr_done: assert property (thresh_check |-> $past(conv_done, 1) ##1 !thresh_check)
    else $error("threshold pulse misplaced");
  cover property ($fell(acquire_on));
  cover property (thresh_check);
  cover property (sel_vref);
endmodule
bind acsf_top acsf_top_assertions u_chk (.core_clk(core_clk), .srst(srst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_start(conv_start), .conv_clk_en(conv_clk_en),
  .precharge_on(precharge_on),
  .acquire_on(acquire_on), .thresh_check(thresh_check), .sel_vref(sel_vref), .sel_dac(sel_dac),
  .sel_temp(sel_temp), .sel_gnd(sel_gnd), .sel_none(sel_none), .sel_port(sel_port));
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench of the sequence and filter block
// Assumes: 40 MHz core_clk, rc pin about 5.7 MHz
// Notes: fixed seed, corner cases before random ones
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic rc_tick = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] dly = 8'h00;
  logic [9:0] smp = 10'h000;
  logic [7:0] reg_rdata, d, h, c, cnt, rpt;
  logic [9:0] conv_result;
  logic conv_done, conv_start, precharge_on, acquire_on, thresh_check;
  logic sel_vref, sel_dac, sel_temp, sel_gnd, sel_none;
  logic [2:0] sel_port, pin_index;
  logic [4:0] cap_pf;
  logic signed [15:0] acc, flt;
  integer seed = 32'h18ff;
  int errors = 0;
  int checks_done = 0;
  logic [7:0] corner [10] = '{8'hff, 8'h3e, 8'h3d, 8'h3c, 8'h3b, 8'h18, 8'h00, 8'h0f, 8'h10, 8'h17};
  logic [15:0] pa [6] = '{16'h0000, 16'h0001, 16'h0100, 16'h0201, 16'hffff, 16'h0700};
  // clocks; rc pin offset so its edges never race a core_clk edge
  always #12.5 core_clk = ~core_clk;
  initial begin
    #3;
    forever #87.5 rc_tick = ~rc_tick;
  end
  acsf_top u_dut (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_tick(rc_tick), .conv_done(conv_done),
    .conv_result(conv_result), .conv_start(conv_start), .conv_clk_en(), .precharge_on(precharge_on),
    .acquire_on(acquire_on), .sel_vref(sel_vref), .sel_dac(sel_dac), .sel_temp(sel_temp),
    .sel_gnd(sel_gnd), .sel_none(sel_none), .sel_port(sel_port), .pin_index(pin_index),
    .cap_pf(cap_pf), .thresh_check(thresh_check));
  acsf_core_model u_core (.core_clk(core_clk), .srst(srst), .conv_start(conv_start), .delay(dly),
    .sample(smp), .conv_done(conv_done), .conv_result(conv_result));
  // expected multiplexer outputs for a channel code
  function automatic logic [10:0] chan_exp(input logic [5:0] k);
    logic [2:0] p;
    p = (k[5:3] == 3'h0) ? 3'h1 : (k[5:3] == 3'h1) ? 3'h2 : (k[5:3] == 3'h2) ? 3'h4 : 3'h0;
    return {k == 6'h3f, k == 6'h3e, k == 6'h3d, k == 6'h3c, k > 6'h17 && k < 6'h3c, p, k[2:0]};
  endfunction
  // core clocks that n rc ticks take: one tick every 7 core clocks, first one 1 to 7 in
  function automatic logic in_span(input logic [15:0] seen, n);
    return (n == 16'h0) ? (seen == 16'h0) : ((seen + 16'h6 >= 7 * n) && (seen <= 7 * n));
  endfunction
  task automatic chk(input string n, input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // bus cycles start one edge in, so strobes never get two assignments at once
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // one conversion: phase lengths, threshold pulse, filter and counter
  task automatic conv(input logic [15:0] pq, input logic src, input logic [2:0] md, sh);
    logic [15:0] np, na, nt, an;
    logic signed [15:0] s;
    np = 16'h0;
    na = 16'h0;
    nt = 16'h0;
    smp <= 10'($random(seed));
    dly <= {5'h0, 3'($random(seed))};
    wr(4'ha, {1'b0, sh, 1'b0, md});
    wr(4'h1, pq[15:8]);
    wr(4'h2, pq[7:0]);
    wr(4'h8, {6'h0, src, 1'b1});
    cnt = (cnt == 8'hff) ? cnt : cnt + 8'h01;
    for (int i = 0; i < 4000 && conv_done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1 np += {15'h0, precharge_on};
      na += {15'h0, acquire_on};
    end
    chk("done", {15'h0, conv_done}, 16'h1);
    repeat (3) begin
      @(posedge core_clk);
      #1 nt += {15'h0, thresh_check};
    end
    s = $signed({6'h0, smp});
    if (md == 3'h4) begin
      acc = acc + ((s - acc) >>> sh);
      flt = acc;
    end else if (md != 3'h0 && md < 3'h4) begin
      acc = acc + s;
      flt = acc >>> sh;
    end
    an = (pq[7:0] != 8'h0) ? {8'h0, pq[7:0]} : (pq[15:8] != 8'h0) ? 16'h100 : 16'h0;
    if (!src) begin
      chk("pre_len", np, {8'h0, pq[15:8]});
      chk("acq_len", na, an);
    end else begin
      chk("rc_pre", {15'h0, in_span(np, {8'h0, pq[15:8]})}, 16'h1);
      chk("rc_acq", {15'h0, in_span(na, an)}, 16'h1);
    end
    chk("thresh", nt, {15'h0, md inside {3'h2, 3'h3, 3'h4} && cnt >= rpt});
    rd(4'h6, h);
    rd(4'h7, d);
    chk("filter", {h, d}, flt);
    rd(4'h5, d);
    chk("counter", {8'h0, d}, {8'h0, cnt});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    cnt = 8'h00;
    rpt = 8'h03;
    acc = 16'sh0;
    flt = 16'sh0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a), d);
      chk("reset", {8'h0, d}, 16'h0);
    end
    $display("test reset values done");
    for (int i = 0; i < 30; i++) begin
      c = (i < 10) ? corner[i] : 8'($random(seed));
      wr(4'h0, c);
      rd(4'h0, d);
      chk("chan_rd", {8'h0, d}, {10'h0, c[5:0]});
      chk("chan_sel", {5'h0, sel_vref, sel_dac, sel_temp, sel_gnd, sel_none, sel_port, pin_index},
        {5'h0, chan_exp(c[5:0])});
      wr(4'h3, c);
      rd(4'h3, d);
      chk("cap_rd", {8'h0, d}, {11'h0, c[4:0]});
      chk("cap_pf", {11'h0, cap_pf}, {11'h0, c[4:0]});
    end
    $display("test channel and capacitor done");
    wr(4'h9, 8'h3f);
    wr(4'h4, rpt);
    wr(4'h5, 8'h20);
    wr(4'ha, 8'h09);
    cnt = 8'h00;
    acc = 16'sh0;
    rd(4'h5, d);
    chk("clear", {8'h0, d}, 16'h0);
    for (int i = 0; i < 6; i++)
      conv(pa[i], 1'b0, 3'(i % 5), 3'(i % 6));
    $display("test corner conversions done");
    for (int i = 0; i < 10; i++)
      conv({4'h0, 4'($random(seed)), 4'h0, 4'($random(seed))}, 1'($random(seed)),
        3'($unsigned($random(seed)) % 6), 3'($unsigned($random(seed)) % 6));
    $display("test random conversions done");
    wr(4'h5, 8'hfe);
    cnt = 8'hfe;
    conv(16'h0101, 1'b0, 3'h2, 3'h1);
    conv(16'h0101, 1'b0, 3'h3, 3'h1);
    $display("test counter saturation done");
    end_sim();
  end
  // hang guard, well above the longest expected run
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
